// >>> src/line_diag_consts.vh
// constants for the line diagnostic monitor: register map, fields, thresholds
// assumes inclusion by bare name from the design file
`ifndef LINE_DIAG_CONSTS_VH
`define LINE_DIAG_CONSTS_VH
`define ADDR_STATUS_FIRST 12'h000
`define ADDR_IRQ_STATUS_FIRST 12'h004
`define ADDR_IRQ_EDGE_SELECT 12'h008
`define ADDR_IRQ_MASK_FIRST 12'h00C
`define ADDR_IRQ_STATUS_THIRD 12'h010
`define ADDR_IRQ_MASK_THIRD 12'h014
`define ADDR_ERROR_REG 12'h018
`define ADDR_LOSS_CONFIG 12'h01C
`define ADDR_RX_CONFIG_FIRST 12'h020
`define ADDR_CLOCK_GROUP 12'h024
`define ADDR_LINE_CONFIG 12'h028
`define BIT_LOSS_STATE 0
`define BIT_LOSS_FLAG 0
`define BIT_LOSS_EDGE 1
`define BIT_LINE_ZEROS 2
`define BIT_SYSTEM_ZEROS 3
`define BIT_LINE_VIOL 4
`define BIT_SYSTEM_VIOL 5
`define BIT_VIOL_INSERT 6
`define BIT_ZERO_RULE 7
`define BIT_LOSS_CRITERIA 7
`define AMP_MSB 6
`define AMP_LSB 4
`define BIT_RX_CLOCK_HOLD 7
`define RX_FMT_MSB 1
`define RX_FMT_LSB 0
`define BIT_MON_CLK_EN 3
`define BIT_MON_CLK_RATE 2
`define BIT_E1_MODE 0
`define CODE_MSB 2
`define CODE_LSB 1
`define BIT_TX_NRZ 3
`define CODE_AMI 2'h0
`define CODE_B8ZS 2'h1
`define CODE_HDB3 2'h2
`define FMT_SLICED 2'h3
`define EXZ_AMI 8'h0F
`define EXZ_AMI_ALT 8'h50
`define EXZ_B8ZS 8'h07
`define EXZ_HDB3 8'h03
`define LOS_N_T1_SHORT 12'h0AF
`define LOS_N_T1_LONG 12'h608
`define LOS_N_E1_SHORT 12'h020
`define LOS_N_E1_LONG 12'h800
`define LOS_M_T1 12'h0AF
`define LOS_M_E1 12'h020
`define LOS_ZRUN_T1 12'h064
`define LOS_ZRUN_E1 12'h010
`define DENSITY_SHIFT 3
`define SLOT_COUNT 5'h16
`define SLOT_LAST 5'h15
`endif

// >>> src/line_diag_monitor.v
// line diagnostic monitor: violations, excessive zeros, line loss, serial loss pins
// assumes bit clocks and line pins arrive asynchronously to sys_clk; APB from sys_clk domain
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "line_diag_consts.vh"

// one coded path: mark polarity, violations and zero strings
module line_code_checker
(
   input wire sys_clk,
   input wire rst,
   input wire bitTick,
   input wire markPos,
   input wire markNeg,
   input wire [1:0] lineCode,
   input wire e1Mode,
   input wire zeroRuleSelect,
   input wire forceAmi,
   input wire checkEnable,
   output reg violation,
   output reg excessZeros
);
   reg lastPol;
   reg haveMark;
   reg lastBpvPol;
   reg haveBpv;
   reg [7:0] zeroCount;
   reg [7:0] zeroLimit;
   wire mark;
   wire bpv;
   wire [1:0] code;
   assign mark = markPos | markNeg;
   assign bpv = mark && haveMark && (lastPol == markPos);
   assign code = forceAmi ? `CODE_AMI : lineCode;
   always @*
   begin
      case (code)
         `CODE_B8ZS: zeroLimit = `EXZ_B8ZS;
         `CODE_HDB3: zeroLimit = `EXZ_HDB3;
         default: zeroLimit = (zeroRuleSelect && !e1Mode) ? `EXZ_AMI_ALT : `EXZ_AMI;
      endcase
   end
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         lastPol <= 1'b0;
         haveMark <= 1'b0;
         lastBpvPol <= 1'b0;
         haveBpv <= 1'b0;
         zeroCount <= 8'h00;
         violation <= 1'b0;
         excessZeros <= 1'b0;
      end
      else
      begin
         violation <= 1'b0;
         excessZeros <= 1'b0;
         if (bitTick)
         begin
            if (mark)
            begin
               lastPol <= markPos;
               haveMark <= 1'b1;
               zeroCount <= 8'h00;
               if (bpv)
               begin
                  lastBpvPol <= markPos;
                  haveBpv <= 1'b1;
                  if (code == `CODE_AMI)
                     violation <= checkEnable;
                  else
                     violation <= checkEnable && haveBpv && (lastBpvPol == markPos);
               end
            end
            else
            begin
               if (zeroCount != 8'hFF)
                  zeroCount <= zeroCount + 8'h01;
               excessZeros <= (zeroCount == zeroLimit);
            end
         end
      end
   end
endmodule // line_code_checker

// Operation
// - same-polarity successive marks flag a bipolar violation on receive and transmit paths.
// - equal-polarity successive violations outside substitution patterns flag a code violation.
// - AMI uses bipolar checking; B8ZS and HDB3 use code checking.
// - single-rail NRZ transmit interface suppresses transmit violation checks.
// - receive violation sets line violation flag bit 4, interrupt unless masked.
// - transmit violation sets system violation flag bit 5, interrupt unless masked.
// - insert bit 6 forces a violation on next transmit mark, then self-clears.
// - zero rule select bit 7 chooses between two excessive-zero definitions.
// - AMI declares after more than 15 zeros; second rule in T1 uses 80.
// - B8ZS declares after more than 7 zeros, HDB3 after more than 3.
// - single-rail NRZ transmit uses AMI zero thresholds whatever the code.
// - receive excessive zeros set line zeros flag bit 2, interrupt unless masked.
// - transmit excessive zeros set system zeros flag bit 3, interrupt unless masked.
// - loss declared when amplitude below selected threshold for N intervals.
// - loss cleared after M intervals from a mark, above Q+250mV, 12.5% density.
// - T1 N is 175 or 1544, M 175, zero run under 100.
// - E1 N is 32 or 2048, M 32, zero run under 16.
// - loss state bit 0; flag on rising or any edge by select bit 1.
// - 22 channel loss bits shift serially, marker high at channel 0 slot.
// - both serial loss pins released while monitor clock disabled.
// - during loss receive data low except sliced; clock high or master clock.
// - alternate data sources during loss override outputs and the clock hold choice.
module line_diag_monitor
#(
   parameter MON_DIV_FAST = 8'h03,
   parameter MON_DIV_SLOW = 8'h3F
)
(
   input wire sys_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   input wire rxBitClock,
   input wire rxMarkPos,
   input wire rxMarkNeg,
   input wire rxAmpBelowQ,
   input wire rxAmpAboveP,
   input wire txBitClock,
   input wire txMarkPos,
   input wire txMarkNeg,
   input wire masterDerivedClock,
   input wire [20:0] otherChannelLoss,
   input wire altActive,
   input wire altData,
   input wire altClock,
   output wire [2:0] amplitudeThresholdSel,
   output reg txOutPos,
   output reg txOutNeg,
   output reg rxDataOut,
   output reg rxRailPos,
   output reg rxRailNeg,
   output reg rxClockOut,
   output reg monitorOutClock,
   output reg serialLossOut,
   output reg serialFrameMarker,
   output wire serialOe_n,
   output wire irqOut
);
   reg [1:0] rxClkSync, rxPosSync, rxNegSync, rxLoSync, rxHiSync;
   reg [1:0] txClkSync, txPosSync, txNegSync, mdcSync;
   reg [20:0] otherSync0, otherSync1;
   reg rxClkLast, txClkLast;
   reg lineLossFlag, lineLossMask, lossEdgeSelect, lineLossState;
   reg [5:2] irqThird, maskThird;
   reg violationInsert, zeroRuleSelect, lossCriteriaSel;
   reg [2:0] ampSel;
   reg rxClockHoldSel;
   reg [1:0] rxFormat;
   reg monClockEnable, monClockRate;
   reg e1Mode, txSingleRailNrz;
   reg [1:0] lineCode;
   reg [11:0] lowCount, winCount, winMarks, zeroRun;
   reg inWindow;
   reg [7:0] divCount;
   reg [4:0] slot;
   reg txLastPol;
   wire rxTick, txTick, lineViol, lineZeros, sysViol, sysZeros;
   wire apbWrite, mapped, insertDone, lossChange;
   wire [11:0] lossN, lossM, zeroRunLimit;
   wire [21:0] lossVector;
   wire [7:0] divLimit;
   reg next_lineLossState;
   reg [31:0] readValue;

   assign rxTick = rxClkSync[1] & ~rxClkLast;
   assign txTick = txClkSync[1] & ~txClkLast;
   assign pready = 1'b1;
   assign apbWrite = psel & penable & pwrite;
   assign mapped = (paddr <= `ADDR_LINE_CONFIG) && (paddr[1:0] == 2'h0);
   assign pslverr = psel & penable & ~mapped;
   assign amplitudeThresholdSel = ampSel;
   assign serialOe_n = ~monClockEnable;
   assign lossVector = {otherSync1, lineLossState};
   assign divLimit = monClockRate ? MON_DIV_FAST : MON_DIV_SLOW;
   assign irqOut = (lineLossFlag & ~lineLossMask) | (|(irqThird & ~maskThird));
   assign insertDone = violationInsert & txTick & (txPosSync[1] | txNegSync[1]);
   assign lossChange = next_lineLossState ^ lineLossState;
   assign lossN = e1Mode ? (lossCriteriaSel ? `LOS_N_E1_LONG : `LOS_N_E1_SHORT)
                         : (lossCriteriaSel ? `LOS_N_T1_LONG : `LOS_N_T1_SHORT);
   assign lossM = e1Mode ? `LOS_M_E1 : `LOS_M_T1;
   assign zeroRunLimit = e1Mode ? `LOS_ZRUN_E1 : `LOS_ZRUN_T1;

   line_code_checker rxChecker
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .bitTick(rxTick),
      .markPos(rxPosSync[1]),
      .markNeg(rxNegSync[1]),
      .lineCode(lineCode),
      .e1Mode(e1Mode),
      .zeroRuleSelect(zeroRuleSelect),
      .forceAmi(1'b0),
      .checkEnable(1'b1),
      .violation(lineViol),
      .excessZeros(lineZeros)
   );

   line_code_checker txChecker
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .bitTick(txTick),
      .markPos(txPosSync[1]),
      .markNeg(txNegSync[1]),
      .lineCode(lineCode),
      .e1Mode(e1Mode),
      .zeroRuleSelect(zeroRuleSelect),
      .forceAmi(txSingleRailNrz),
      .checkEnable(~txSingleRailNrz),
      .violation(sysViol),
      .excessZeros(sysZeros)
   );

   // input synchronisers
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rxClkSync <= 2'h0;
         rxPosSync <= 2'h0;
         rxNegSync <= 2'h0;
         rxLoSync <= 2'h0;
         rxHiSync <= 2'h0;
         txClkSync <= 2'h0;
         txPosSync <= 2'h0;
         txNegSync <= 2'h0;
         mdcSync <= 2'h0;
         otherSync0 <= 21'h000000;
         otherSync1 <= 21'h000000;
         rxClkLast <= 1'b0;
         txClkLast <= 1'b0;
      end
      else
      begin
         rxClkSync <= {rxClkSync[0], rxBitClock};
         rxPosSync <= {rxPosSync[0], rxMarkPos};
         rxNegSync <= {rxNegSync[0], rxMarkNeg};
         rxLoSync <= {rxLoSync[0], rxAmpBelowQ};
         rxHiSync <= {rxHiSync[0], rxAmpAboveP};
         txClkSync <= {txClkSync[0], txBitClock};
         txPosSync <= {txPosSync[0], txMarkPos};
         txNegSync <= {txNegSync[0], txMarkNeg};
         mdcSync <= {mdcSync[0], masterDerivedClock};
         otherSync0 <= otherChannelLoss;
         otherSync1 <= otherSync0;
         rxClkLast <= rxClkSync[1];
         txClkLast <= txClkSync[1];
      end
   end

   // line loss declare and clear
   always @*
   begin
      next_lineLossState = lineLossState;
      if (rxTick && !lineLossState && rxLoSync[1] && (lowCount + 12'h001 >= lossN))
         next_lineLossState = 1'b1;
      if (rxTick && lineLossState && inWindow && (winCount + 12'h001 >= lossM) &&
          rxHiSync[1] && (zeroRun + 12'h001 < zeroRunLimit) &&
          (((winMarks + {11'h000, rxPosSync[1] | rxNegSync[1]}) << `DENSITY_SHIFT) >= lossM))
         next_lineLossState = 1'b0;
   end

   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         lineLossState <= 1'b0;
         lowCount <= 12'h000;
         winCount <= 12'h000;
         winMarks <= 12'h000;
         zeroRun <= 12'h000;
         inWindow <= 1'b0;
      end
      else
      begin
         lineLossState <= next_lineLossState;
         if (rxTick)
         begin
            lowCount <= (rxLoSync[1] && !lineLossState && !next_lineLossState) ? lowCount + 12'h001 : 12'h000;
            if (!lineLossState || next_lineLossState != lineLossState)
               inWindow <= 1'b0;
            else if (!inWindow || !rxHiSync[1] || (zeroRun + 12'h001 >= zeroRunLimit) ||
                     (winCount + 12'h001 >= lossM))
            begin
               // window restarts only on a strong mark
               inWindow <= rxHiSync[1] & (rxPosSync[1] | rxNegSync[1]);
               winCount <= 12'h001;
               winMarks <= 12'h001;
               zeroRun <= 12'h000;
            end
            else
            begin
               winCount <= winCount + 12'h001;
               if (rxPosSync[1] | rxNegSync[1])
               begin
                  winMarks <= winMarks + 12'h001;
                  zeroRun <= 12'h000;
               end
               else
                  zeroRun <= zeroRun + 12'h001;
            end
         end
      end
   end

   // registers, flags with set winning over clear
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         lineLossFlag <= 1'b0;
         lineLossMask <= 1'b1;
         lossEdgeSelect <= 1'b0;
         irqThird <= 4'h0;
         maskThird <= 4'hF;
         violationInsert <= 1'b0;
         zeroRuleSelect <= 1'b0;
         lossCriteriaSel <= 1'b0;
         ampSel <= 3'h0;
         rxClockHoldSel <= 1'b0;
         rxFormat <= 2'h0;
         monClockEnable <= 1'b0;
         monClockRate <= 1'b0;
         e1Mode <= 1'b0;
         txSingleRailNrz <= 1'b0;
         lineCode <= 2'h0;
         prdata <= 32'h00000000;
      end
      else
      begin
         if (psel && !penable)
            prdata <= readValue;
         if (apbWrite && paddr == `ADDR_IRQ_STATUS_FIRST && pwdata[`BIT_LOSS_FLAG])
            lineLossFlag <= 1'b0;
         if (lossChange && (next_lineLossState || lossEdgeSelect))
            lineLossFlag <= 1'b1;
         if (apbWrite && paddr == `ADDR_IRQ_STATUS_THIRD)
            irqThird <= (irqThird & ~pwdata[5:2]) | {sysViol, lineViol, sysZeros, lineZeros};
         else
            irqThird <= irqThird | {sysViol, lineViol, sysZeros, lineZeros};
         if (apbWrite && paddr == `ADDR_ERROR_REG)
         begin
            zeroRuleSelect <= pwdata[`BIT_ZERO_RULE];
            if (pwdata[`BIT_VIOL_INSERT])
               violationInsert <= 1'b1;
            else if (insertDone)
               violationInsert <= 1'b0;
         end
         else if (insertDone)
            violationInsert <= 1'b0;
         if (apbWrite)
         begin
            case (paddr)
               `ADDR_IRQ_EDGE_SELECT: lossEdgeSelect <= pwdata[`BIT_LOSS_EDGE];
               `ADDR_IRQ_MASK_FIRST: lineLossMask <= pwdata[`BIT_LOSS_FLAG];
               `ADDR_IRQ_MASK_THIRD: maskThird <= pwdata[5:2];
               `ADDR_LOSS_CONFIG:
               begin
                  lossCriteriaSel <= pwdata[`BIT_LOSS_CRITERIA];
                  ampSel <= pwdata[`AMP_MSB:`AMP_LSB];
               end
               `ADDR_RX_CONFIG_FIRST:
               begin
                  rxClockHoldSel <= pwdata[`BIT_RX_CLOCK_HOLD];
                  rxFormat <= pwdata[`RX_FMT_MSB:`RX_FMT_LSB];
               end
               `ADDR_CLOCK_GROUP:
               begin
                  monClockEnable <= pwdata[`BIT_MON_CLK_EN];
                  monClockRate <= pwdata[`BIT_MON_CLK_RATE];
               end
               `ADDR_LINE_CONFIG:
               begin
                  e1Mode <= pwdata[`BIT_E1_MODE];
                  lineCode <= pwdata[`CODE_MSB:`CODE_LSB];
                  txSingleRailNrz <= pwdata[`BIT_TX_NRZ];
               end
               default: e1Mode <= e1Mode;
            endcase
         end
      end
   end

   always @*
   begin
      readValue = 32'h00000000;
      case (paddr)
         `ADDR_STATUS_FIRST: readValue[`BIT_LOSS_STATE] = lineLossState;
         `ADDR_IRQ_STATUS_FIRST: readValue[`BIT_LOSS_FLAG] = lineLossFlag;
         `ADDR_IRQ_EDGE_SELECT: readValue[`BIT_LOSS_EDGE] = lossEdgeSelect;
         `ADDR_IRQ_MASK_FIRST: readValue[`BIT_LOSS_FLAG] = lineLossMask;
         `ADDR_IRQ_STATUS_THIRD: readValue[5:2] = irqThird;
         `ADDR_IRQ_MASK_THIRD: readValue[5:2] = maskThird;
         `ADDR_ERROR_REG: readValue[7:6] = {zeroRuleSelect, violationInsert};
         `ADDR_LOSS_CONFIG: readValue[7:4] = {lossCriteriaSel, ampSel};
         `ADDR_RX_CONFIG_FIRST: readValue[7:0] = {rxClockHoldSel, 5'h00, rxFormat};
         `ADDR_CLOCK_GROUP: readValue[3:2] = {monClockEnable, monClockRate};
         `ADDR_LINE_CONFIG: readValue[3:0] = {txSingleRailNrz, lineCode, e1Mode};
         default: readValue = 32'h00000000;
      endcase
   end

   // transmit output with violation insertion
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         txOutPos <= 1'b0;
         txOutNeg <= 1'b0;
         txLastPol <= 1'b0;
      end
      else if (txTick)
      begin
         if (insertDone)
         begin
            // repeat last polarity to force a violation
            txOutPos <= txLastPol;
            txOutNeg <= ~txLastPol;
         end
         else
         begin
            txOutPos <= txPosSync[1];
            txOutNeg <= txNegSync[1];
            if (txPosSync[1] | txNegSync[1])
               txLastPol <= txPosSync[1];
         end
      end
   end

   // receive output substitution during loss
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rxDataOut <= 1'b0;
         rxRailPos <= 1'b0;
         rxRailNeg <= 1'b0;
         rxClockOut <= 1'b0;
      end
      else if (altActive)
      begin
         rxDataOut <= altData;
         rxRailPos <= altData;
         rxRailNeg <= 1'b0;
         rxClockOut <= altClock;
      end
      else if (lineLossState && rxFormat != `FMT_SLICED)
      begin
         rxDataOut <= 1'b0;
         rxRailPos <= 1'b0;
         rxRailNeg <= 1'b0;
         rxClockOut <= rxClockHoldSel ? mdcSync[1] : 1'b1;
      end
      else
      begin
         rxDataOut <= rxPosSync[1] | rxNegSync[1];
         rxRailPos <= rxPosSync[1];
         rxRailNeg <= rxNegSync[1];
         rxClockOut <= lineLossState ? (rxClockHoldSel ? mdcSync[1] : 1'b1) : rxClkSync[1];
      end
   end

   // serial loss indication on monitor clock
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         divCount <= 8'h00;
         monitorOutClock <= 1'b0;
         slot <= 5'h00;
         serialLossOut <= 1'b0;
         serialFrameMarker <= 1'b0;
      end
      else if (!monClockEnable)
      begin
         divCount <= 8'h00;
         monitorOutClock <= 1'b0;
      end
      else if (divCount >= divLimit)
      begin
         divCount <= 8'h00;
         monitorOutClock <= ~monitorOutClock;
         if (!monitorOutClock)
         begin
            serialLossOut <= lossVector[slot];
            serialFrameMarker <= (slot == 5'h00);
            slot <= (slot == `SLOT_LAST) ? 5'h00 : slot + 5'h01;
         end
      end
      else
         divCount <= divCount + 8'h01;
   end
endmodule // line_diag_monitor

// >>> testbench/line_diag_checker.sv
// port checker for the line diagnostic monitor
// assumes binding to the monitor; one sys_clk domain
`timescale 1ns/1ps
module line_diag_checker
(
   input wire sys_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire [11:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire altActive,
   input wire altData,
   input wire txOutPos,
   input wire txOutNeg,
   input wire rxRailPos,
   input wire rxRailNeg,
   input wire monitorOutClock,
   input wire serialFrameMarker,
   input wire serialOe_n
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   reg prevClk;
   reg started;
   reg [4:0] riseCnt;
   wire rise;
   assign rise = monitorOutClock && !prevClk;
   sequence s_bad_setup;
      psel && !penable && paddr > 12'h028;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   // slots counted between two channel 0 markers
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         prevClk <= 1'b0;
         started <= 1'b0;
         riseCnt <= 5'h00;
      end
      else
      begin
         prevClk <= monitorOutClock;
         if (rise)
            riseCnt <= serialFrameMarker ? 5'h00 : riseCnt + 5'h01;
         started <= !serialOe_n && (started || (rise && serialFrameMarker));
      end
   end
   chk_ready_high: assert property (pready)
      else $error("pready low");
   chk_bad_addr: assert property (s_bad_setup ##1 s_access |-> pslverr)
      else $error("unmapped access without error");
   chk_good_addr: assert property (s_access and (paddr <= 12'h028 && paddr[1:0] == 2'h0) |-> !pslverr)
      else $error("mapped access with error");
   chk_idle_quiet: assert property (!penable |-> !pslverr)
      else $error("error outside access");
   chk_tx_rails: assert property (!(txOutPos && txOutNeg))
      else $error("both tx rails high");
   chk_alt_rails: assert property (altActive ##1 altActive |-> rxRailPos == $past(altData) && !rxRailNeg)
      else $error("alternate data not on rx rails");
   chk_clock_idle: assert property (serialOe_n ##1 serialOe_n |-> !monitorOutClock)
      else $error("monitor clock runs while released");
   chk_marker_edge: assert property ($changed(serialFrameMarker) && !serialOe_n |-> $rose(monitorOutClock))
      else $error("marker moved off clock rise");
   chk_marker_period: assert property (rise && serialFrameMarker && started |-> riseCnt == 5'h15)
      else $error("marker period not 22 slots");
endmodule // line_diag_checker
bind line_diag_monitor line_diag_checker chk (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .altActive(altActive), .altData(altData),
   .txOutPos(txOutPos), .txOutNeg(txOutNeg), .rxRailPos(rxRailPos), .rxRailNeg(rxRailNeg),
   .monitorOutClock(monitorOutClock), .serialFrameMarker(serialFrameMarker), .serialOe_n(serialOe_n));

// >>> testbench/line_side_model.sv
// line side model: bipolar marks with their bit clocks
// assumes sys_clk paces the pulse intervals
`timescale 1ns/1ps
module line_side_model
(
   input wire sys_clk,
   output reg rxBitClock = 1'b0,
   output reg rxMarkPos = 1'b0,
   output reg rxMarkNeg = 1'b0,
   output reg txBitClock = 1'b0,
   output reg txMarkPos = 1'b0,
   output reg txMarkNeg = 1'b0
);
   // sym bit0 positive mark, bit1 negative mark; held 4 cycles before the rise and 8 after
   task sendBit(input tx, input [1:0] sym);
   begin
      @(posedge sys_clk);
      if (tx)
         {txMarkNeg, txMarkPos} <= sym;
      else
         {rxMarkNeg, rxMarkPos} <= sym;
      repeat (4) @(posedge sys_clk);
      if (tx)
         txBitClock <= 1'b1;
      else
         rxBitClock <= 1'b1;
      repeat (4) @(posedge sys_clk);
      {txBitClock, rxBitClock} <= 2'h0;
      repeat (4) @(posedge sys_clk);
      {txMarkNeg, txMarkPos, rxMarkNeg, rxMarkPos} <= 4'h0;
   end
   endtask
endmodule // line_side_model

// >>> testbench/line_diag_monitor_tb_top.sv
// bench for the line diagnostic monitor over APB and line pins
// assumes the line side model and the bound port checker
`timescale 1ns/1ps
`include "line_diag_consts.vh"
module line_diag_monitor_tb_top;
   reg sys_clk = 1'b0;
   reg rst = 1'b1;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg belowQ = 1'b0;
   reg aboveP = 1'b0;
   reg altActive = 1'b0;
   reg altData = 1'b0;
   wire pready, pslverr, rxDataOut, rxClockOut, txOutPos, txOutNeg, serialOe_n, irqOut;
   wire [31:0] prdata;
   wire rbc, rmp, rmn, tbc, tmp, tmn;
   integer n_mismatch = 0;
   integer compares = 0;
   integer i;
   reg [31:0] rd;
   reg err;
   reg tx;
   reg [1:0] pol;
   reg [1:0] prx = 2'h2;
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) altData <= ~altData;
   line_side_model lineSide (.sys_clk(sys_clk), .rxBitClock(rbc), .rxMarkPos(rmp), .rxMarkNeg(rmn),
      .txBitClock(tbc), .txMarkPos(tmp), .txMarkNeg(tmn));
   line_diag_monitor uut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .rxBitClock(rbc), .rxMarkPos(rmp), .rxMarkNeg(rmn), .rxAmpBelowQ(belowQ), .rxAmpAboveP(aboveP),
      .txBitClock(tbc), .txMarkPos(tmp), .txMarkNeg(tmn), .masterDerivedClock(1'b0),
      .otherChannelLoss(21'h000001), .altActive(altActive), .altData(altData), .altClock(1'b0),
      .amplitudeThresholdSel(), .txOutPos(txOutPos), .txOutNeg(txOutNeg), .rxDataOut(rxDataOut),
      .rxRailPos(), .rxRailNeg(), .rxClockOut(rxClockOut), .monitorOutClock(), .serialLossOut(),
      .serialFrameMarker(), .serialOe_n(serialOe_n), .irqOut(irqOut));
   task check(input [63:0] nm, input [31:0] s, input [31:0] e);
   begin
      compares = compares + 1;
      if (s !== e)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %0s exp %h seen %h", nm, e, s);
      end
   end
   endtask
   // one APB transfer; called right after a rising edge
   task apb(input w, input [11:0] a, input [31:0] d);
   begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   end
   endtask
   task rdc(input [11:0] a, input [63:0] nm, input [31:0] e);
   begin
      apb(1'b0, a, 32'h0);
      check(nm, rd, e);
   end
   endtask
   task send(input t, input [1:0] sym, input integer n);
      integer k;
   begin
      for (k = 0; k < n; k = k + 1)
         lineSide.sendBit(t, sym);
   end
   endtask
   task complete_run;
   begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch = n_mismatch + 1;
      complete_run;
   end
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rdc(`ADDR_IRQ_MASK_THIRD, "mask3", 32'h3C);
      check("irq", irqOut, 32'h0);
      apb(1'b0, 12'h02C, 32'h0);
      check("slverr", err, 32'h1);
      check("badrd", rd, 32'h0);
      $display("reset and map done");
      apb(1'b1, `ADDR_IRQ_MASK_THIRD, 32'h0);
      for (i = 0; i < 2; i = i + 1)
      begin
         send(i, 2'h1, 2);
         rdc(`ADDR_IRQ_STATUS_THIRD, "viol", i ? 32'h20 : 32'h10);
         check("irq", irqOut, 32'h1);
         apb(1'b1, `ADDR_IRQ_STATUS_THIRD, 32'h3C);
         check("irqclr", irqOut, 32'h0);
      end
      apb(1'b1, `ADDR_LINE_CONFIG, 32'h4);
      send(0, 2'h2, 2);
      rdc(`ADDR_IRQ_STATUS_THIRD, "cv", 32'h0);
      $display("violations done");
      // AMI, B8ZS, HDB3, AMI second rule, tx single rail under HDB3
      for (i = 0; i < 5; i = i + 1)
      begin
         tx = (i == 4);
         apb(1'b1, `ADDR_LINE_CONFIG, (i == 1) ? 32'h2 : (i == 2) ? 32'h4 : tx ? 32'hC : 32'h0);
         apb(1'b1, `ADDR_ERROR_REG, (i == 3) ? 32'h80 : 32'h0);
         pol = tx ? 2'h1 : 2'h3 - prx;
         prx = tx ? prx : pol;
         send(tx, pol, 1);
         rdc(`ADDR_IRQ_STATUS_THIRD, "mark", 32'h0);
         send(tx, 2'h0, (i == 1) ? 7 : (i == 2) ? 3 : (i == 3) ? 80 : 15);
         rdc(`ADDR_IRQ_STATUS_THIRD, "atlimit", 32'h0);
         send(tx, 2'h0, 1);
         rdc(`ADDR_IRQ_STATUS_THIRD, "zeros", tx ? 32'h08 : 32'h04);
         apb(1'b1, `ADDR_IRQ_STATUS_THIRD, 32'h3C);
      end
      $display("zero strings done");
      apb(1'b1, `ADDR_LINE_CONFIG, 32'h0);
      send(1'b1, 2'h2, 1);
      apb(1'b1, `ADDR_ERROR_REG, 32'h40);
      rdc(`ADDR_ERROR_REG, "insset", 32'h40);
      send(1'b1, 2'h1, 1);
      check("txrails", {txOutNeg, txOutPos}, 32'h2);
      rdc(`ADDR_ERROR_REG, "insclr", 32'h0);
      $display("insertion done");
      apb(1'b1, `ADDR_LINE_CONFIG, 32'h1);
      apb(1'b1, `ADDR_IRQ_EDGE_SELECT, 32'h2);
      belowQ <= 1'b1;
      send(1'b0, 2'h0, 31);
      rdc(`ADDR_STATUS_FIRST, "noloss", 32'h0);
      send(1'b0, 2'h0, 1);
      rdc(`ADDR_STATUS_FIRST, "loss", 32'h1);
      rdc(`ADDR_IRQ_STATUS_FIRST, "lossflag", 32'h1);
      check("rxout", {rxClockOut, rxDataOut}, 32'h2);
      apb(1'b1, `ADDR_IRQ_STATUS_FIRST, 32'h1);
      belowQ <= 1'b0;
      aboveP <= 1'b1;
      for (i = 0; i < 34; i = i + 1)
         lineSide.sendBit(1'b0, i[0] ? 2'h2 : 2'h1);
      rdc(`ADDR_STATUS_FIRST, "cleared", 32'h0);
      rdc(`ADDR_IRQ_STATUS_FIRST, "clrflag", 32'h1);
      $display("line loss done");
      altActive <= 1'b1;
      apb(1'b1, `ADDR_CLOCK_GROUP, 32'hC);
      repeat (400) @(posedge sys_clk);
      check("oe", serialOe_n, 32'h0);
      apb(1'b1, `ADDR_CLOCK_GROUP, 32'h0);
      repeat (4) @(posedge sys_clk);
      check("oeoff", serialOe_n, 32'h1);
      $display("serial pins done");
      complete_run;
   end
endmodule // line_diag_monitor_tb_top
